// ### sysctl_cfg.svh
// Register offsets, field positions, reset values and wakeup timing constants.
// Assumes an 8-bit APB byte address decode and a 10 MHz bus clock.
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH

// Byte offsets of the registers on the APB slave.
`define OFS_OPTIONS       8'h00
`define OFS_CLOCK_OUT     8'h04
`define OFS_ID_HIGH       8'h08
`define OFS_ID_LOW        8'h0c
`define OFS_WAKEUP        8'h10

// Field positions.
`define OPT_WDOG_EN_BIT   7
`define OPT_WDOG_LONG_BIT 6
`define OPT_STOP_BIT      5
`define CLK_EN_BIT        4
`define WAKE_FLAG_BIT     7
`define WAKE_ACK_BIT      6
`define WAKE_SRC_BIT      5
`define WAKE_IE_BIT       4

// Reset values.
`define OPT_WDOG_EN_RST   1'b1
`define OPT_WDOG_LONG_RST 1'b1
`define OPT_STOP_RST      1'b0
`define CLK_EN_RST        1'b0
`define CLK_DIV_RST       3'h0
`define WAKE_IE_RST       1'b0
`define WAKE_SEL_RST      3'h0

// Wakeup delays on the internal oscillator, in milliseconds, and its rate.
`define WAKE_OSC_HZ       1000
`define WAKE_MS_1         8
`define WAKE_MS_2         32
`define WAKE_MS_3         64
`define WAKE_MS_4         128
`define WAKE_MS_5         256
`define WAKE_MS_6         512
`define WAKE_MS_7         1024
`define WAKE_MS_TICKS(ms) ((ms) * `WAKE_OSC_HZ / 1000)

// Wakeup dividers on the external crystal clock.
`define WAKE_XDIV_1       256
`define WAKE_XDIV_2       1024
`define WAKE_XDIV_3       2048
`define WAKE_XDIV_4       4096
`define WAKE_XDIV_5       8192
`define WAKE_XDIV_6       16384
`define WAKE_XDIV_7       32768

`endif

// ### sysctl_pkg.sv
// Types shared by the system options and wakeup control block.
// Assumes nothing beyond a SystemVerilog compiler.
package sysctl_pkg;
	typedef logic [2:0] divider_t;
	typedef logic [2:0] delay_sel_t;
	typedef enum logic [0:0] {WAKE_SRC_INTERNAL = 1'b0, WAKE_SRC_EXTERNAL = 1'b1} wake_src_t;
	typedef enum logic [2:0] {
		SEL_OPT  = 3'h0,
		SEL_CLK  = 3'h1,
		SEL_IDH  = 3'h2,
		SEL_IDL  = 3'h3,
		SEL_WAKE = 3'h4,
		SEL_NONE = 3'h7
	} reg_sel_t;
endpackage

// ### ctrl_link_if.sv
// Settings and status passed between the register bank and its two helpers.
// Assumes all three modules share one clock.
`timescale 1ns/1ps
interface ctrl_link_if;
	import sysctl_pkg::*;
	logic       clk_out_en;
	divider_t   clk_out_div;
	logic       clk_out_pin;
	logic       clk_out_oe;
	wake_src_t  wake_src;
	delay_sel_t wake_sel;
	logic       wake_restart;
	logic       wake_timeout;

	modport ctrl (output clk_out_en, output clk_out_div, input clk_out_pin, input clk_out_oe,
		output wake_src, output wake_sel, output wake_restart, input wake_timeout);
	modport divider (input clk_out_en, input clk_out_div, output clk_out_pin,
		output clk_out_oe);
	modport timer (input wake_src, input wake_sel, input wake_restart, output wake_timeout);
endinterface

// ### clock_out_divider.sv
// Divided bus clock for the clock output pin.
// Assumes the settings come from registers on the same clock.
`timescale 1ns/1ps
module clock_out_divider
	import sysctl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	ctrl_link_if.divider link
);
	logic [2:0] cnt_q;
	logic       pin_q;
	logic       oe_q;
	logic [3:0] run_q;

	// The pin toggles every N bus cycles, giving bus rate over 2N; a zero code holds it low.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !link.clk_out_en || link.clk_out_div == 3'h0)
		begin
			cnt_q <= 3'h0;
			pin_q <= 1'b0; // R10
		end
		else if (cnt_q >= link.clk_out_div - 3'h1)
		begin
			cnt_q <= 3'h0;
			pin_q <= ~pin_q; // R9
		end
		else
			cnt_q <= cnt_q + 3'h1;
	end

	// The pin is driven only while the output function is enabled.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			oe_q <= 1'b0;
		else
			oe_q <= link.clk_out_en; // R8
	end

	assign link.clk_out_pin = pin_q;
	assign link.clk_out_oe  = oe_q;

	// Helper that measures each half period of the output.
	// Zero marks a half period disturbed by enabling or by a divider change, which is not checked.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || !link.clk_out_en || $changed(link.clk_out_div))
			run_q <= 4'h0;
		else if (pin_q != $past(pin_q))
			run_q <= 4'h1;
		else if (run_q != 4'hf && run_q != 4'h0)
			run_q <= run_q + 4'h1;
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_half_period;
		link.clk_out_en && $stable(link.clk_out_div) && pin_q != $past(pin_q) && run_q != 4'h0
			|-> run_q == {1'b0, link.clk_out_div};
	endproperty
	a_half_period: assert property (p_half_period) else $error("Clock output half period wrong."); // R9

	property p_zero_low;
		link.clk_out_en && link.clk_out_div == 3'h0 |=> !pin_q;
	endproperty
	a_zero_low: assert property (p_zero_low) else $error("Clock output not held low."); // R10

	c_toggle: cover property (link.clk_out_en && $rose(pin_q));
endmodule

// ### wakeup_timer.sv
// Periodic wakeup timer counting internal oscillator or crystal clock edges.
// Assumes both sources arrive as asynchronous pins far slower than the bus clock.
`timescale 1ns/1ps
`include "sysctl_cfg.svh"
module wakeup_timer
	import sysctl_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_n_i,
	input  wire logic wake_osc_i,
	input  wire logic wake_xtal_i,
	ctrl_link_if.timer link
);
	logic [1:0]  s1_q;
	logic [1:0]  s2_q;
	logic [1:0]  s3_q;
	logic [1:0]  lvl_q;
	logic [1:0]  rise;
	logic        tick;
	logic [15:0] cnt_q;
	logic        timeout_q;

	// Last count of a period for each source and delay code.
	function automatic logic [15:0] wake_limit(input wake_src_t src, input delay_sel_t sel);
		int n;
		n = 1;
		unique case (sel)
			3'h1: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_1 : `WAKE_MS_TICKS(`WAKE_MS_1);
			3'h2: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_2 : `WAKE_MS_TICKS(`WAKE_MS_2);
			3'h3: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_3 : `WAKE_MS_TICKS(`WAKE_MS_3);
			3'h4: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_4 : `WAKE_MS_TICKS(`WAKE_MS_4);
			3'h5: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_5 : `WAKE_MS_TICKS(`WAKE_MS_5);
			3'h6: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_6 : `WAKE_MS_TICKS(`WAKE_MS_6);
			3'h7: n = (src == WAKE_SRC_EXTERNAL) ? `WAKE_XDIV_7 : `WAKE_MS_TICKS(`WAKE_MS_7);
			3'h0: n = 1;
		endcase
		return 16'(n - 1);
	endfunction

	// Three-stage synchronisers; a level counts only once stages two and three agree.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			s1_q  <= 2'h0;
			s2_q  <= 2'h0;
			s3_q  <= 2'h0;
			lvl_q <= 2'h0;
		end
		else
		begin
			s1_q  <= {wake_xtal_i, wake_osc_i};
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));
		end
	end

	assign rise = s2_q & s3_q & ~lvl_q;
	assign tick = (link.wake_src == WAKE_SRC_EXTERNAL) ? rise[1] : rise[0]; // R15

	// Counts source edges and pulses the timeout once per period; code zero stops it.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i || link.wake_restart || link.wake_sel == 3'h0) // R17
		begin
			cnt_q     <= 16'h0000;
			timeout_q <= 1'b0;
		end
		else if (tick && cnt_q >= wake_limit(link.wake_src, link.wake_sel))
		begin
			cnt_q     <= 16'h0000;
			timeout_q <= 1'b1; // R18 R19
		end
		else
		begin
			cnt_q     <= tick ? cnt_q + 16'h0001 : cnt_q;
			timeout_q <= 1'b0;
		end
	end

	assign link.wake_timeout = timeout_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_disabled;
		link.wake_sel == 3'h0 |=> !timeout_q;
	endproperty
	a_disabled: assert property (p_disabled) else $error("Wakeup timed out while disabled."); // R17
endmodule

// ### system_options_wakeup_ctrl.sv
// Register bank for system options, clock output, part number and periodic wakeup.
// Assumes an APB3 master on clk_i and a processor that pulses stop_attempt_i.
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "sysctl_cfg.svh"

// Notes on behaviour
// R1 - Options register takes only the first write after reset; reads always allowed.
// R2 - Options bits 3 and 2 are absent and read zero.
// R3 - Options bit 7 enables the watchdog, reset value one.
// R4 - Options bit 6 picks long watchdog timeout when one, reset value one.
// R5 - Options bit 5 permits stop mode, reset value zero.
// R6 - A stop attempt without permission forces an illegal-opcode reset.
// R7 - Software should write the options register once during initialisation.
// R8 - Clock control bit 4 enables the divided clock on its pin.
// R9 - Nonzero divider N gives bus clock divided by 2N on the pin.
// R10 - Divider zero with output enabled holds the pin low.
// R11 - A fixed 12-bit part number reads through high and low registers.
// R12 - High identity bits 7:4 are reserved; writes do nothing.
// R13 - Wakeup flag bit 7 sets on timer timeout.
// R14 - Writing one to acknowledge bit 6 clears the flag; it reads zero.
// R15 - Bit 5 picks the wakeup clock: internal oscillator or crystal.
// R16 - Bit 4 enables wakeup interrupt requests.
// R17 - Delay code zero stops the wakeup timer.
// R18 - Internal source delays are 8 to 1024 ms for codes one to seven.
// R19 - Crystal source delays divide by 256 to 32768 for codes one to seven.
// R20 - Unused wakeup control bits read zero.
// R21 - Interrupt request follows flag and enable, drops after acknowledge.
module system_options_wakeup_ctrl
	import sysctl_pkg::*;
#(
	parameter int          ADDR_W      = 8,
	parameter logic [11:0] PART_NUMBER = 12'h5a3 // Value is arbitrary.
)
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              psel_i,
	input  wire logic              penable_i,
	input  wire logic              pwrite_i,
	input  wire logic [ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]       pwdata_i,
	output logic      [31:0]       prdata_o,
	output logic                   pready_o,
	output logic                   pslverr_o,
	input  wire logic              stop_attempt_i,
	input  wire logic              wake_osc_i,
	input  wire logic              wake_xtal_i,
	output logic                   watchdog_enable_o,
	output logic                   watchdog_long_timeout_o,
	output logic                   stop_enter_o,
	output logic                   illegal_stop_reset_o,
	output logic                   clock_out_port_pin_o,
	output logic                   clock_out_port_pin_oe_o,
	output logic                   wakeup_irq_o
);
	ctrl_link_if link ();

	logic       pready_q;
	logic [31:0] prdata_q;
	logic       pslverr_q;
	logic       options_written_q;
	logic       watchdog_enable_q;
	logic       watchdog_long_timeout_q;
	logic       stop_permit_q;
	logic       clock_out_pin_enable_q;
	divider_t   clock_out_divider_q;
	logic       wakeup_flag_q;
	wake_src_t  wakeup_clock_select_q;
	logic       wakeup_interrupt_enable_q;
	delay_sel_t wakeup_delay_select_q;
	logic       wakeup_restart_q;
	logic       wakeup_irq_q;
	logic       stop_enter_q;
	logic       illegal_stop_q;
	reg_sel_t   sel;
	logic       access;
	logic       wr_en;
	logic       wr_opt;
	logic       wr_clk;
	logic       wr_wake;
	logic       ack_wr;
	logic [7:0] rd_byte;

	// The decode logic reads the low eight address bits.
	if (ADDR_W < 8)
	begin : g_chk
		$error("ADDR_W must be at least 8.");
	end

	// Maps a byte address onto one register, or none.
	function automatic reg_sel_t decode(input logic [ADDR_W-1:0] addr);
		reg_sel_t s;
		s = SEL_NONE;
		if ((addr >> 8) == '0)
		begin
			unique case (addr[7:0])
				`OFS_OPTIONS:   s = SEL_OPT;
				`OFS_CLOCK_OUT: s = SEL_CLK;
				`OFS_ID_HIGH:   s = SEL_IDH;
				`OFS_ID_LOW:    s = SEL_IDL;
				`OFS_WAKEUP:    s = SEL_WAKE;
				default:        s = SEL_NONE;
			endcase
		end
		return s;
	endfunction

	// Bus decode; a write lands only at the edge where pready is seen high.
	assign sel     = decode(paddr_i);
	assign access  = psel_i && penable_i;
	assign wr_en   = access && pready_q && pwrite_i;
	assign wr_opt  = wr_en && sel == SEL_OPT;
	assign wr_clk  = wr_en && sel == SEL_CLK;
	assign wr_wake = wr_en && sel == SEL_WAKE;
	assign ack_wr  = wr_wake && pwdata_i[`WAKE_ACK_BIT];

	// Read value of the addressed register; absent and write-only bits read zero.
	always_comb
	begin
		rd_byte = 8'h00;
		unique case (sel)
			SEL_OPT:
			begin
				rd_byte[`OPT_WDOG_EN_BIT]   = watchdog_enable_q;
				rd_byte[`OPT_WDOG_LONG_BIT] = watchdog_long_timeout_q;
				rd_byte[`OPT_STOP_BIT]      = stop_permit_q; // R2
			end
			SEL_CLK:
			begin
				rd_byte[`CLK_EN_BIT] = clock_out_pin_enable_q;
				rd_byte[2:0]         = clock_out_divider_q;
			end
			SEL_IDH: rd_byte = {4'h0, PART_NUMBER[11:8]}; // R11 R12
			SEL_IDL: rd_byte = PART_NUMBER[7:0]; // R11
			SEL_WAKE:
			begin
				rd_byte[`WAKE_FLAG_BIT] = wakeup_flag_q; // R14 R20
				rd_byte[`WAKE_SRC_BIT]  = wakeup_clock_select_q;
				rd_byte[`WAKE_IE_BIT]   = wakeup_interrupt_enable_q;
				rd_byte[2:0]            = wakeup_delay_select_q;
			end
			SEL_NONE: rd_byte = 8'h00;
		endcase
	end

	// One wait state: pready rises in the second access cycle, with data and error.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
		else if (access && !pready_q)
		begin
			pready_q  <= 1'b1;
			prdata_q  <= pwrite_i ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			pslverr_q <= sel == SEL_NONE;
		end
		else
		begin
			pready_q  <= 1'b0;
			prdata_q  <= 32'h0000_0000;
			pslverr_q <= 1'b0;
		end
	end

	// Write-once options; the lock guards the watchdog against runaway code.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			options_written_q       <= 1'b0;
			watchdog_enable_q       <= `OPT_WDOG_EN_RST; // R3
			watchdog_long_timeout_q <= `OPT_WDOG_LONG_RST; // R4
			stop_permit_q           <= `OPT_STOP_RST; // R5
		end
		else if (wr_opt && !options_written_q) // R1
		begin
			options_written_q       <= 1'b1;
			watchdog_enable_q       <= pwdata_i[`OPT_WDOG_EN_BIT]; // R3
			watchdog_long_timeout_q <= pwdata_i[`OPT_WDOG_LONG_BIT]; // R4
			stop_permit_q           <= pwdata_i[`OPT_STOP_BIT]; // R5
		end
	end

	// Clock output control, freely rewritable.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			clock_out_pin_enable_q <= `CLK_EN_RST;
			clock_out_divider_q    <= `CLK_DIV_RST;
		end
		else if (wr_clk)
		begin
			clock_out_pin_enable_q <= pwdata_i[`CLK_EN_BIT]; // R8
			clock_out_divider_q    <= pwdata_i[2:0]; // R9
		end
	end

	// Wakeup settings; any write restarts the period so a new delay starts clean.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			wakeup_clock_select_q     <= WAKE_SRC_INTERNAL;
			wakeup_interrupt_enable_q <= `WAKE_IE_RST;
			wakeup_delay_select_q     <= `WAKE_SEL_RST;
			wakeup_restart_q          <= 1'b0;
		end
		else
		begin
			wakeup_restart_q <= wr_wake;
			if (wr_wake)
			begin
				wakeup_clock_select_q     <= wake_src_t'(pwdata_i[`WAKE_SRC_BIT]); // R15
				wakeup_interrupt_enable_q <= pwdata_i[`WAKE_IE_BIT]; // R16
				wakeup_delay_select_q     <= pwdata_i[2:0]; // R17
			end
		end
	end

	// Sticky flag; a timeout in the acknowledge cycle wins over the clear.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			wakeup_flag_q <= 1'b0;
		else
			wakeup_flag_q <= link.wake_timeout || (wakeup_flag_q && !ack_wr); // R13 R14
	end

	// Interrupt request, one cycle behind the flag and enable.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			wakeup_irq_q <= 1'b0;
		else
			wakeup_irq_q <= wakeup_flag_q && wakeup_interrupt_enable_q; // R16 R21
	end

	// Stop attempts either enter stop or force the illegal-opcode reset.
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			stop_enter_q   <= 1'b0;
			illegal_stop_q <= 1'b0;
		end
		else
		begin
			stop_enter_q   <= stop_attempt_i && stop_permit_q;
			illegal_stop_q <= stop_attempt_i && !stop_permit_q; // R6
		end
	end

	// Settings out to the helpers.
	assign link.clk_out_en   = clock_out_pin_enable_q;
	assign link.clk_out_div  = clock_out_divider_q;
	assign link.wake_src     = wakeup_clock_select_q;
	assign link.wake_sel     = wakeup_delay_select_q;
	assign link.wake_restart = wakeup_restart_q;

	clock_out_divider u_clock_out_divider (
		.clk_i   (clk_i),
		.rst_n_i (rst_n_i),
		.link    (link.divider)
	);

	wakeup_timer u_wakeup_timer (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.wake_osc_i  (wake_osc_i),
		.wake_xtal_i (wake_xtal_i),
		.link        (link.timer)
	);

	// Outputs, each from a flip-flop.
	assign prdata_o                = prdata_q;
	assign pready_o                = pready_q;
	assign pslverr_o               = pslverr_q;
	assign watchdog_enable_o       = watchdog_enable_q;
	assign watchdog_long_timeout_o = watchdog_long_timeout_q;
	assign stop_enter_o            = stop_enter_q;
	assign illegal_stop_reset_o    = illegal_stop_q;
	assign clock_out_port_pin_o    = link.clk_out_pin;
	assign clock_out_port_pin_oe_o = link.clk_out_oe;
	assign wakeup_irq_o            = wakeup_irq_q;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_once_locked;
		options_written_q ##1 wr_opt |=> $stable(watchdog_enable_q) && $stable(stop_permit_q)
			&& $stable(watchdog_long_timeout_q);
	endproperty
	a_once_locked: assert property (p_once_locked) else $error("Options changed after lock."); // R1

	property p_opt_rsv;
		access && !pready_q && !pwrite_i && sel == SEL_OPT |=> prdata_o[3:2] == 2'h0;
	endproperty
	a_opt_rsv: assert property (p_opt_rsv) else $error("Options bits 3:2 not zero."); // R2

	property p_wdog_first;
		wr_opt && !options_written_q |=> watchdog_enable_o == $past(pwdata_i[7]);
	endproperty
	a_wdog_first: assert property (p_wdog_first) else $error("Watchdog enable not taken."); // R3

	property p_illegal_stop;
		stop_attempt_i && !stop_permit_q |=> illegal_stop_reset_o && !stop_enter_o;
	endproperty
	a_illegal_stop: assert property (p_illegal_stop) else $error("Illegal stop not reset."); // R6

	property p_ack_clears;
		wakeup_flag_q && ack_wr && !link.wake_timeout |=> !wakeup_flag_q ##1 !wakeup_irq_o;
	endproperty
	a_ack_clears: assert property (p_ack_clears) else $error("Acknowledge left the flag."); // R14

	property p_flag_set;
		link.wake_timeout |=> wakeup_flag_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("Timeout did not set the flag."); // R13

	property p_irq;
		wakeup_flag_q && wakeup_interrupt_enable_q |=> wakeup_irq_o;
	endproperty
	a_irq: assert property (p_irq) else $error("Interrupt request missing."); // R21

	property p_idh;
		access && !pready_q && !pwrite_i && sel == SEL_IDH |=> prdata_o == {28'h0, PART_NUMBER[11:8]};
	endproperty
	a_idh: assert property (p_idh) else $error("Identity high read wrong."); // R11

	property p_pready;
		access && !pready_q |=> pready_o ##1 !pready_o;
	endproperty
	a_pready: assert property (p_pready) else $error("APB answer timing wrong.");

	c_relock: cover property (options_written_q && wr_opt);
	c_wakeup: cover property (link.wake_timeout && wakeup_interrupt_enable_q);
	c_illegal: cover property (stop_attempt_i && !stop_permit_q);
endmodule

// ### system_options_wakeup_ctrl_tb_top.sv
// Self-checking bench for the system options, clock output, part number and wakeup bank.
// Assumes the design files and sysctl_cfg.svh compile ahead of it, and a 10 MHz bus clock.
`timescale 1ns/1ps
`include "sysctl_cfg.svh"
module system_options_wakeup_ctrl_tb_top;
	import sysctl_pkg::*;
	localparam logic [11:0] PART  = 12'h3c6; // Value is arbitrary.
	localparam int          LIMIT = 60000;
	logic        clk_i, rst_n_i, psel, penable, pwrite, stop_attempt, wake_osc, wake_xtal;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, wd_en, wd_long, stop_enter, illegal, pin, pin_oe, irq;
	logic [33:0] exp_q[$];
	logic [33:0] e;
	int          n_errors, n_compared, cycles;
	int          wake_n[8] = '{0, `WAKE_MS_1, `WAKE_MS_2, `WAKE_MS_3, `WAKE_MS_4,
		`WAKE_MS_5, `WAKE_MS_6, `WAKE_MS_7};

	system_options_wakeup_ctrl #(.ADDR_W(8), .PART_NUMBER(PART)) dut (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .stop_attempt_i(stop_attempt),
		.wake_osc_i(wake_osc), .wake_xtal_i(wake_xtal), .watchdog_enable_o(wd_en),
		.watchdog_long_timeout_o(wd_long), .stop_enter_o(stop_enter),
		.illegal_stop_reset_o(illegal), .clock_out_port_pin_o(pin),
		.clock_out_port_pin_oe_o(pin_oe), .wakeup_irq_o(irq)
	);

	// Bus clock at 100 ns period.
	always #50 clk_i = ~clk_i;

	task check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task results();
		$display("errors %0d, comparisons %0d", n_errors, n_compared);
		if (n_errors == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// One APB transfer; the expected answer is queued for the monitor before the request goes out.
	// The request stands until the rising edge at which pready is sampled high; only the
	// hang guard ends a wait that never completes.
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
		input logic [31:0] exp, input logic err);
		exp_q.push_back({~wr, err, exp});
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_i);
		penable <= 1'b1;
		do
			@(posedge clk_i);
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk_i);
	endtask

	task idle(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// Pin levels last 3 to 5 clocks so the three-flop synchroniser never misses an edge.
	task edges(input logic xt, input int n);
		int l;
		repeat (n)
		begin
			l = $urandom_range(5, 3);
			if (xt) wake_xtal <= 1'b1; else wake_osc <= 1'b1;
			idle(l);
			if (xt) wake_xtal <= 1'b0; else wake_osc <= 1'b0;
			idle(l);
		end
	endtask

	// A stop attempt answers with exactly one single-cycle pulse on the matching output.
	task stop_try(input logic [1:0] exp);
		stop_attempt <= 1'b1;
		@(posedge clk_i);
		stop_attempt <= 1'b0;
		@(negedge clk_i);
		check({30'h0, illegal, stop_enter}, {30'h0, exp});
		@(negedge clk_i);
		check({30'h0, illegal, stop_enter}, 32'h0);
		@(posedge clk_i);
	endtask

	// Counts clocks between two changes of the output pin.
	task period(input int n);
		int c;
		logic p;
		c = 0;
		p = pin;
		while (pin === p && c < 40) begin @(negedge clk_i); c++; end
		c = 0;
		p = pin;
		while (pin === p && c < 40) begin @(negedge clk_i); c++; end
		check(32'(c), 32'(n));
		@(posedge clk_i);
	endtask

	// Monitor: at the edge that completes a transfer, the answer takes the oldest expectation.
	always @(posedge clk_i)
		if (pready === 1'b1)
		begin
			if (exp_q.size() == 0)
			begin
				n_errors++;
				$display("unexpected at %0t: answer with nothing pending", $time);
			end
			else
			begin
				e = exp_q.pop_front();
				check(32'(pslverr), 32'(e[32]));
				if (e[33]) check(prdata, e[31:0]);
			end
		end

	// Hang guard: a run that outlives the budget ends as a failure.
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == LIMIT)
		begin
			n_errors++;
			results();
		end
	end

	// Main sequence.
	initial
	begin
		clk_i = 1'b0; rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h00; pwdata = 32'h0; stop_attempt = 1'b0; wake_osc = 1'b0; wake_xtal = 1'b0;
		void'($urandom(32'h2f9b1dda));
		idle(20);
		rst_n_i <= 1'b1;
		@(negedge clk_i);
		check({28'h0, wd_en, wd_long, pin_oe, irq}, 32'hc);
		@(posedge clk_i);
		apb(1'b0, `OFS_OPTIONS, 32'h0, 32'hc0, 1'b0);
		stop_try(2'b10);
		apb(1'b1, `OFS_OPTIONS, {24'($urandom), 8'h2f}, 32'h0, 1'b0);
		apb(1'b1, `OFS_OPTIONS, 32'hff, 32'h0, 1'b0);
		apb(1'b0, `OFS_OPTIONS, 32'h0, 32'h20, 1'b0);
		check({30'h0, wd_en, wd_long}, 32'h0);
		stop_try(2'b01);
		// A second reset must reopen the write-once options.
		rst_n_i <= 1'b0;
		idle(3);
		rst_n_i <= 1'b1;
		idle(1);
		check({30'h0, wd_en, wd_long}, 32'h3);
		apb(1'b1, `OFS_OPTIONS, 32'h40, 32'h0, 1'b0);
		apb(1'b0, `OFS_OPTIONS, 32'h0, 32'h40, 1'b0);
		check({30'h0, wd_en, wd_long}, 32'h1);
		apb(1'b1, `OFS_ID_HIGH, 32'hff, 32'h0, 1'b0);
		apb(1'b1, `OFS_ID_LOW, 32'h00, 32'h0, 1'b0);
		apb(1'b0, `OFS_ID_HIGH, 32'h0, {28'h0, PART[11:8]}, 1'b0);
		apb(1'b0, `OFS_ID_LOW, 32'h0, {24'h0, PART[7:0]}, 1'b0);
		apb(1'b0, 8'h14, 32'h0, 32'h0, 1'b1);
		apb(1'b1, 8'h14, 32'hff, 32'h0, 1'b1);
		for (int n = 0; n < 8; n++)
		begin
			apb(1'b1, `OFS_CLOCK_OUT, {24'($urandom), 8'h10 | 8'(n)}, 32'h0, 1'b0);
			apb(1'b0, `OFS_CLOCK_OUT, 32'h0, 32'h10 | 32'(n), 1'b0);
			check(32'(pin_oe), 32'h1);
			if (n == 0)
				repeat (5) begin @(negedge clk_i); check(32'(pin), 32'h0); end
			else
				period(2 * n - n);
		end
		apb(1'b1, `OFS_CLOCK_OUT, 32'h0, 32'h0, 1'b0);
		idle(3);
		check({30'h0, pin, pin_oe}, 32'h0);
		for (int k = 1; k < 8; k++)
		begin
			apb(1'b1, `OFS_WAKEUP, 32'h10 | 32'(k), 32'h0, 1'b0);
			edges(1'b0, wake_n[k] - 1);
			idle(8);
			apb(1'b0, `OFS_WAKEUP, 32'h0, 32'h10 | 32'(k), 1'b0);
			edges(1'b0, 1);
			idle(8);
			apb(1'b0, `OFS_WAKEUP, 32'h0, 32'h90 | 32'(k), 1'b0);
			check(32'(irq), 32'h1);
			apb(1'b1, `OFS_WAKEUP, 32'h50 | 32'(k), 32'h0, 1'b0);
			apb(1'b0, `OFS_WAKEUP, 32'h0, 32'h10 | 32'(k), 1'b0);
			check(32'(irq), 32'h0);
		end
		apb(1'b1, `OFS_WAKEUP, 32'h21, 32'h0, 1'b0);
		edges(1'b0, 300);
		edges(1'b1, `WAKE_XDIV_1 - 1);
		idle(8);
		apb(1'b0, `OFS_WAKEUP, 32'h0, 32'h21, 1'b0);
		edges(1'b1, 1);
		idle(8);
		apb(1'b0, `OFS_WAKEUP, 32'h0, 32'ha1, 1'b0);
		check(32'(irq), 32'h0);
		apb(1'b1, `OFS_WAKEUP, 32'h50, 32'h0, 1'b0);
		edges(1'b0, 20);
		idle(8);
		apb(1'b0, `OFS_WAKEUP, 32'h0, 32'h10, 1'b0);
		check(32'(irq), 32'h0);
		idle(4);
		results();
	end
endmodule
